// ===== hdl/ais_decode.sv
// decodes control bits into analog switch enables
`timescale 1ns/1ps
module ais_decode (
    input wire logic [7:0] ctl,
    input wire logic shift_req,
    input wire logic shift_allow,
    output ais_pkg::ais_src_e src,
    output logic offset_en,
    output logic offset_bypass,
    output logic [ais_pkg::PIN_COUNT-1:0] pin_sw,
    output logic supply_sw,
    output logic ground_sw
);

    logic direct;
    logic halved;
    logic [ais_pkg::PIN_COUNT-1:0] pins;

    // source of the sample capacitor and comparator 2 minus input
    always_comb begin
        direct = ctl[ais_pkg::CTL_DIRECT_BIT];
        halved = ctl[ais_pkg::CTL_HALVED_BIT];
        pins = ctl[ais_pkg::CTL_PIN_LSB +: ais_pkg::PIN_COUNT];
        case ({direct, halved})
            2'b00: src = ais_pkg::AIS_SRC_HOLD;
            2'b01: src = ais_pkg::AIS_SRC_HALVED;
            2'b10: src = ais_pkg::AIS_SRC_DIRECT;
            default: src = ais_pkg::AIS_SRC_DIODE;
        endcase
        // offset only while holding, and only if the option allows it
        offset_en = !direct && !halved && shift_req && shift_allow;
        offset_bypass = direct || halved;
        // pins close independently, in any mix
        pin_sw = pins;
        supply_sw = ctl[ais_pkg::CTL_SUPPLY_BIT] && (pins == '0);
        ground_sw = !ctl[ais_pkg::CTL_SUPPLY_BIT] && (pins == '0);
    end

endmodule

// ===== hdl/ais_pkg.sv
// shared constants and types for the analog input select block
package ais_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses, one aligned word each)
    // ----------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam logic [3:0] CTL_OFFSET = 4'h0;
    localparam logic [3:0] AUX_OFFSET = 4'h4;
    localparam logic [3:0] STAT_OFFSET = 4'h8;

    // ----------------------------------------------------------------
    // control register fields
    // ----------------------------------------------------------------
    localparam int CTL_DIRECT_BIT = 7;
    localparam int CTL_HALVED_BIT = 6;
    localparam int CTL_SWAP_BIT = 5;
    localparam int CTL_SUPPLY_BIT = 4;
    localparam int CTL_PIN_LSB = 0;
    localparam int PIN_COUNT = 4;
    localparam logic [7:0] CTL_RESET = 8'h80;

    // ----------------------------------------------------------------
    // auxiliary register fields (offset shift and its option)
    // ----------------------------------------------------------------
    localparam int AUX_SHIFT_BIT = 0;
    localparam int AUX_OPTION_BIT = 1;
    localparam logic [7:0] AUX_RESET = 8'h00;
    localparam logic [7:0] AUX_MASK = 8'h03;

    // ----------------------------------------------------------------
    // status register fields
    // ----------------------------------------------------------------
    localparam int STAT_CMP1_BIT = 0;
    localparam int STAT_CMP2_BIT = 1;
    localparam int STAT_SWAP_TOG_BIT = 2;
    localparam int STAT_MIXED_WR_BIT = 3;
    localparam int STAT_GROUND_BIT = 4;
    localparam int STAT_SUPPLY_BIT = 5;
    localparam logic [7:0] STAT_W1C_MASK = 8'h0c;

    // ----------------------------------------------------------------
    // bus answers and sample-capacitor source modes
    // ----------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECODE_ERR = 2'h3;

    typedef enum logic [1:0] {
        AIS_SRC_HOLD,
        AIS_SRC_HALVED,
        AIS_SRC_DIRECT,
        AIS_SRC_DIODE
    } ais_src_e;

endpackage

// ===== hdl/ais_sync2.sv
// two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module ais_sync2 #(
    parameter int WIDTH = 2
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } ais_sync_s;

    ais_sync_s s_q;
    ais_sync_s s_d;

    // first stage is read only by the second stage
    always_comb begin
        s_d.meta = async_in;
        s_d.stable = s_q.meta;
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sync_out = s_q.stable;

endmodule

// ===== hdl/ais_top.sv
// analog input select: register slave and switch enable logic
//
// Chosen here: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
module ais_top (
    input wire logic mclk,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [ais_pkg::ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic [1:0] response,
    output logic waitrequest,
    // raw comparator outputs from the analog side
    input wire logic cmp1_raw,
    input wire logic cmp2_raw,
    // sample capacitor source enables
    output logic cap_hold_en,
    output logic cap_halved_en,
    output logic cap_direct_en,
    output logic cap_diode_en,
    output logic cap_offset_en,
    output logic cap_offset_bypass,
    // channel select bus switches
    output logic [ais_pkg::PIN_COUNT-1:0] bus_pin_en,
    output logic bus_supply_en,
    output logic bus_ground_en,
    // comparator input exchange and corrected levels
    output logic cmp_swap_en,
    output logic cmp1_level,
    output logic cmp2_level
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [1:0] resp;
        logic [7:0] ctl;
        logic [7:0] aux;
        logic swap_tog;
        logic mixed_wr;
        logic cmp1;
        logic cmp2;
        logic hold;
        logic halved;
        logic direct;
        logic diode;
        logic offset;
        logic bypass;
        logic [ais_pkg::PIN_COUNT-1:0] pins;
        logic supply;
        logic ground;
    } ais_state_s;

    ais_state_s s_q;
    ais_state_s s_d;

    // synchroniser and decoder results
    logic [1:0] cmp_sync;
    ais_pkg::ais_src_e src_nx;
    logic offset_nx;
    logic bypass_nx;
    logic [ais_pkg::PIN_COUNT-1:0] pins_nx;
    logic supply_nx;
    logic ground_nx;

    // bus decode and write path
    logic access;
    logic take;
    logic hit_ctl;
    logic hit_aux;
    logic hit_stat;
    logic hit_any;
    logic lane0_wr;
    logic [7:0] wbyte;
    logic [7:0] ctl_nx;
    logic [7:0] aux_nx;

    // write-order watch and status
    logic sample_changed;
    logic select_changed;
    logic [7:0] stat_view;

    // ----------------------------------------------------------------
    // comparator levels cross in through two flops
    // and trail the raw outputs by three edges
    // ----------------------------------------------------------------
    ais_sync2 #(
        .WIDTH(2)
    ) u_cmp_sync (
        .mclk(mclk),
        .rst(rst),
        .async_in({cmp2_raw, cmp1_raw}),
        .sync_out(cmp_sync)
    );

    // ----------------------------------------------------------------
    // switch decode works on the next control value, so the registered
    // enables land on the same edge as the write itself
    // at the cost of a longer path from the bus
    // ----------------------------------------------------------------
    ais_decode u_decode (
        .ctl(ctl_nx),
        .shift_req(aux_nx[ais_pkg::AUX_SHIFT_BIT]),
        .shift_allow(aux_nx[ais_pkg::AUX_OPTION_BIT]),
        .src(src_nx),
        .offset_en(offset_nx),
        .offset_bypass(bypass_nx),
        .pin_sw(pins_nx),
        .supply_sw(supply_nx),
        .ground_sw(ground_nx)
    );

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    // unmapped offsets get a decode error
    always_comb begin
        hit_ctl = 1'b0;
        hit_aux = 1'b0;
        hit_stat = 1'b0;
        if (address == ais_pkg::CTL_OFFSET) begin
            hit_ctl = 1'b1;
        end else if (address == ais_pkg::AUX_OFFSET) begin
            hit_aux = 1'b1;
        end else if (address == ais_pkg::STAT_OFFSET) begin
            hit_stat = 1'b1;
        end

        // any hit answers okay
        hit_any = hit_ctl || hit_aux || hit_stat;
    end

    // one wait cycle per access; the request is taken on the second edge
    assign access = read || write;
    assign take = access && s_q.ack;

    // only lane 0 holds register bits
    assign lane0_wr = take && write && byteenable[0];
    assign wbyte = writedata[7:0];

    // next control value: only a taken write to lane 0 changes it
    always_comb begin
        ctl_nx = s_q.ctl;
        if (lane0_wr && hit_ctl) begin
            ctl_nx = wbyte;
        end
    end

    // next shift bits, kept out of the state copy so the decoder
    // input does not loop back into the next-state process;
    // unused bits are masked off and read as zero
    always_comb begin
        aux_nx = s_q.aux;
        if (lane0_wr && hit_aux) begin
            aux_nx = wbyte & ais_pkg::AUX_MASK;
        end
    end

    // write-order hazard: sample bits and channel selects changed together
    // raises a sticky flag only; the write still lands
    always_comb begin
        sample_changed = (ctl_nx[ais_pkg::CTL_DIRECT_BIT] != s_q.ctl[ais_pkg::CTL_DIRECT_BIT])
            || (ctl_nx[ais_pkg::CTL_HALVED_BIT] != s_q.ctl[ais_pkg::CTL_HALVED_BIT]);

        // the supply bit counts as a select
        select_changed = (ctl_nx[ais_pkg::CTL_SUPPLY_BIT] != s_q.ctl[ais_pkg::CTL_SUPPLY_BIT])
            || (ctl_nx[ais_pkg::CTL_PIN_LSB +: ais_pkg::PIN_COUNT]
            != s_q.ctl[ais_pkg::CTL_PIN_LSB +: ais_pkg::PIN_COUNT]);
    end

    // status view assembled from live state
    // bits 7:6 read as zero
    always_comb begin
        stat_view = 8'h00;
        stat_view[ais_pkg::STAT_CMP1_BIT] = s_q.cmp1;
        stat_view[ais_pkg::STAT_CMP2_BIT] = s_q.cmp2;
        stat_view[ais_pkg::STAT_SWAP_TOG_BIT] = s_q.swap_tog;
        stat_view[ais_pkg::STAT_MIXED_WR_BIT] = s_q.mixed_wr;
        // rail bits mirror the registered switches
        stat_view[ais_pkg::STAT_GROUND_BIT] = s_q.ground;
        stat_view[ais_pkg::STAT_SUPPLY_BIT] = s_q.supply;
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s_d = s_q;

        // handshake: ack rises on the first cycle of a request and
        // drops on the edge that takes it, so back-to-back works
        // a request dropped while waiting is forgotten
        s_d.ack = access && !s_q.ack;

        // read data is captured while waiting, ready when ack is high
        if (access && !s_q.ack) begin
            s_d.rdata = 32'h0000_0000;
            s_d.resp = hit_any ? ais_pkg::RESP_OKAY
                : ais_pkg::RESP_DECODE_ERR;
            // writes read back zero
            if (read) begin
                if (hit_ctl) begin
                    s_d.rdata[7:0] = s_q.ctl;
                end else if (hit_aux) begin
                    s_d.rdata[7:0] = s_q.aux;
                end else if (hit_stat) begin
                    s_d.rdata[7:0] = stat_view;
                end
            end
        end

        // control register; decoded value already holds the write
        s_d.ctl = ctl_nx;

        // offset shift and its enabling option
        s_d.aux = aux_nx;

        // sticky flags: clear by writing one, a new event wins the clear
        if (lane0_wr && hit_stat) begin
            // a clear loses to a new event below
            if (wbyte[ais_pkg::STAT_SWAP_TOG_BIT]) begin
                s_d.swap_tog = 1'b0;
            end
            if (wbyte[ais_pkg::STAT_MIXED_WR_BIT]) begin
                s_d.mixed_wr = 1'b0;
            end
        end

        // a swap toggle may leave stale comparator flags behind
        if (ctl_nx[ais_pkg::CTL_SWAP_BIT] != s_q.ctl[ais_pkg::CTL_SWAP_BIT]) begin
            s_d.swap_tog = 1'b1;
        end
        // sample bits and selects changed in one write can upset the hold
        if (sample_changed && select_changed) begin
            s_d.mixed_wr = 1'b1;
        end

        // undo the internal exchange so levels keep their pin sense;
        // uses the current swap setting, which may differ from the one in force while the sample was taken
        s_d.cmp1 = cmp_sync[0] ^ s_q.ctl[ais_pkg::CTL_SWAP_BIT];
        s_d.cmp2 = cmp_sync[1] ^ s_q.ctl[ais_pkg::CTL_SWAP_BIT];

        // registered switch enables, exactly one source at a time
        s_d.hold = (src_nx == ais_pkg::AIS_SRC_HOLD);
        s_d.halved = (src_nx == ais_pkg::AIS_SRC_HALVED);
        s_d.direct = (src_nx == ais_pkg::AIS_SRC_DIRECT);
        s_d.diode = (src_nx == ais_pkg::AIS_SRC_DIODE);

        // offset path and channel bus
        s_d.offset = offset_nx;
        s_d.bypass = bypass_nx;
        s_d.pins = pins_nx;
        s_d.supply = supply_nx;
        s_d.ground = ground_nx;
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    // reset state: direct sampling of a grounded bus, so the capacitor
    // drains to the ground reference right after reset
    // every field is named, so none powers up unknown
    always_ff @(posedge mclk) begin
        if (rst) begin
            // bus side idle
            s_q.ack <= 1'b0;
            s_q.rdata <= 32'h0000_0000;
            s_q.resp <= ais_pkg::RESP_OKAY;

            // registers
            s_q.ctl <= ais_pkg::CTL_RESET;
            s_q.aux <= ais_pkg::AUX_RESET;

            // flags and levels
            s_q.swap_tog <= 1'b0;
            s_q.mixed_wr <= 1'b0;
            s_q.cmp1 <= 1'b0;
            s_q.cmp2 <= 1'b0;

            // direct source on a grounded bus
            s_q.hold <= 1'b0;
            s_q.halved <= 1'b0;
            s_q.direct <= 1'b1;
            s_q.diode <= 1'b0;
            s_q.offset <= 1'b0;
            s_q.bypass <= 1'b1;
            s_q.pins <= '0;
            s_q.supply <= 1'b0;
            s_q.ground <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // waitrequest is combinational so a request never sees a stale low
    // a request always waits exactly one cycle
    assign waitrequest = access && !s_q.ack;

    // data hold until the next request starts
    assign readdata = s_q.rdata;
    assign response = s_q.resp;

    // analog switch enables straight from flops, glitch free
    assign cap_hold_en = s_q.hold;
    assign cap_halved_en = s_q.halved;
    assign cap_direct_en = s_q.direct;
    assign cap_diode_en = s_q.diode;
    assign cap_offset_en = s_q.offset;
    assign cap_offset_bypass = s_q.bypass;
    assign bus_pin_en = s_q.pins;
    assign bus_supply_en = s_q.supply;
    assign bus_ground_en = s_q.ground;

    // comparator side
    assign cmp_swap_en = s_q.ctl[ais_pkg::CTL_SWAP_BIT];
    assign cmp1_level = s_q.cmp1;
    assign cmp2_level = s_q.cmp2;

endmodule

// ===== tb/ais_analog_model.sv
// behavioural model of the comparator pair behind the swap switches
`timescale 1ns/1ps
module ais_analog_model #(
    parameter int LAG = 2
) (
    input wire logic mclk,
    input wire logic swap_en,
    input wire logic cmp1_true,
    input wire logic cmp2_true,
    output logic cmp1_raw,
    output logic cmp2_raw
);
    logic [2*LAG-1:0] pipe_q = '0;
    // slow comparators: a decision needs LAG clocks to reach the output
    always @(posedge mclk) begin
        pipe_q <= {pipe_q[2*LAG-3:0], cmp2_true, cmp1_true};
    end
    // exchanged inputs invert the raw decision; the block must undo it
    assign cmp1_raw = pipe_q[2*LAG-2] ^ swap_en;
    assign cmp2_raw = pipe_q[2*LAG-1] ^ swap_en;
endmodule

// ===== tb/ais_assertions.sv
// concurrent checks on the ports of the analog input select block
`timescale 1ns/1ps
module ais_assertions (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [ais_pkg::ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic [1:0] response,
    input wire logic waitrequest,
    input wire logic cmp1_raw,
    input wire logic cmp2_raw,
    input wire logic cap_hold_en,
    input wire logic cap_halved_en,
    input wire logic cap_direct_en,
    input wire logic cap_diode_en,
    input wire logic cap_offset_en,
    input wire logic cap_offset_bypass,
    input wire logic [ais_pkg::PIN_COUNT-1:0] bus_pin_en,
    input wire logic bus_supply_en,
    input wire logic bus_ground_en,
    input wire logic cmp_swap_en,
    input wire logic cmp1_level,
    input wire logic cmp2_level
);
    // ------------------------------
    // helper logic
    // ------------------------------
    logic wr_ctl;
    logic wr_aux;
    logic rd_bad;
    logic [2:0] run_q;
    // taking edges of writes, and reads of unmapped places
    assign wr_ctl = write && !waitrequest && byteenable[0] && address == ais_pkg::CTL_OFFSET;
    assign wr_aux = write && !waitrequest && byteenable[0] && address == ais_pkg::AUX_OFFSET;
    assign rd_bad = read && !waitrequest && !(address inside {4'h0, 4'h4, 4'h8});
    // cycles since reset; synchroniser holds stale levels until this saturates
    always_ff @(posedge mclk) begin
        if (rst) begin
            run_q <= 3'h0;
        end else if (run_q != 3'h7) begin
            run_q <= run_q + 3'h1;
        end
    end
    // ------------------------------
    // properties
    // ------------------------------
    property p_src;
        @(posedge mclk) disable iff (rst)
        wr_ctl |=> cap_hold_en == ($past(writedata[7:6]) == 2'b00) && cap_halved_en == ($past(writedata[7:6]) == 2'b01)
            && cap_direct_en == ($past(writedata[7:6]) == 2'b10) && cap_diode_en == ($past(writedata[7:6]) == 2'b11);
    endproperty
    a_src: assert property (p_src) else $error("source enables differ from written sample bits");
    property p_bus;
        @(posedge mclk) disable iff (rst)
        wr_ctl |=> bus_pin_en == $past(writedata[3:0]) && cmp_swap_en == $past(writedata[5])
            && bus_supply_en == ($past(writedata[4:0]) == 5'h10) && bus_ground_en == ($past(writedata[4:0]) == 5'h00);
    endproperty
    a_bus: assert property (p_bus) else $error("bus switches differ from written select bits");
    property p_aux;
        @(posedge mclk) disable iff (rst)
        wr_aux |=> cap_offset_en == (cap_hold_en && $past(writedata[1:0]) == 2'b11);
    endproperty
    a_aux: assert property (p_aux) else $error("offset enable wrong after shift write");
    property p_offset;
        @(posedge mclk) disable iff (rst)
        cap_offset_en |-> cap_hold_en && !cap_offset_bypass;
    endproperty
    a_offset: assert property (p_offset) else $error("offset applied outside hold case");
    property p_bypass;
        @(posedge mclk) disable iff (rst)
        cap_offset_bypass == (cap_halved_en || cap_direct_en || cap_diode_en);
    endproperty
    a_bypass: assert property (p_bypass) else $error("offset bypass wrong for source");
    property p_rails;
        @(posedge mclk) disable iff (rst)
        (bus_supply_en || bus_ground_en) |-> bus_pin_en == 4'h0 && !(bus_supply_en && bus_ground_en);
    endproperty
    a_rails: assert property (p_rails) else $error("rail switch closed with another source");
    property p_reset;
        @(posedge mclk) disable iff (rst)
        $fell(rst) |-> cap_direct_en && !cap_halved_en && bus_ground_en && bus_pin_en == 4'h0 && !cmp_swap_en;
    endproperty
    a_reset: assert property (p_reset) else $error("outputs wrong after reset");
    property p_level;
        @(posedge mclk) disable iff (rst)
        (run_q == 3'h7 && $stable(cmp_swap_en) && $past(cmp_swap_en, 2) == cmp_swap_en
            && $past(cmp_swap_en, 3) == cmp_swap_en)
            |-> cmp1_level == ($past(cmp1_raw, 3) ^ cmp_swap_en) && cmp2_level == ($past(cmp2_raw, 3) ^ cmp_swap_en);
    endproperty
    a_level: assert property (p_level) else $error("comparator level not corrected for swap");
    property p_wait;
        @(posedge mclk) disable iff (rst)
        $rose(read || write) |-> waitrequest ##1 !waitrequest;
    endproperty
    a_wait: assert property (p_wait) else $error("request not answered after one wait cycle");
    property p_decode;
        @(posedge mclk) disable iff (rst)
        rd_bad |-> response == ais_pkg::RESP_DECODE_ERR && readdata == 32'h0000_0000;
    endproperty
    a_decode: assert property (p_decode) else $error("unmapped read not refused");
endmodule

// ===== tb/testbench.sv
// self-checking bench for the analog input select block
`timescale 1ns/1ps
module testbench;
    // ------------------------------
    // pins and bench state
    // ------------------------------
    logic mclk = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0, cmp1_true = 1'b0, cmp2_true = 1'b0;
    logic [3:0] address = 4'h0, byteenable = 4'h0, bus_pin_en;
    logic [31:0] writedata = 32'h0000_0000, readdata, rd;
    logic [1:0] response, rs, aux_q;
    logic waitrequest, cmp1_raw, cmp2_raw, cap_hold_en, cap_halved_en, cap_direct_en, cap_diode_en;
    logic cap_offset_en, cap_offset_bypass, bus_supply_en, bus_ground_en, cmp_swap_en, cmp1_level, cmp2_level;
    logic [7:0] cur_q, corner [8] = '{8'h10, 8'h00, 8'h1f, 8'h2f, 8'h40, 8'h80, 8'hc0, 8'hf0};
    logic [12:0] outs;
    logic [15:0] lfsr_q = 16'hd8cc;
    int failures = 0, n_compared = 0;
    assign outs = {cap_hold_en, cap_halved_en, cap_direct_en, cap_diode_en, cap_offset_en, cap_offset_bypass,
                   bus_pin_en, bus_supply_en, bus_ground_en, cmp_swap_en};
    // free-running clock, 50 ns period
    always #25 mclk = ~mclk;
    ais_top dut (
        .mclk(mclk), .rst(rst), .address(address), .read(read), .write(write), .byteenable(byteenable),
        .writedata(writedata), .readdata(readdata), .response(response), .waitrequest(waitrequest),
        .cmp1_raw(cmp1_raw), .cmp2_raw(cmp2_raw), .cap_hold_en(cap_hold_en), .cap_halved_en(cap_halved_en),
        .cap_direct_en(cap_direct_en), .cap_diode_en(cap_diode_en), .cap_offset_en(cap_offset_en),
        .cap_offset_bypass(cap_offset_bypass), .bus_pin_en(bus_pin_en), .bus_supply_en(bus_supply_en),
        .bus_ground_en(bus_ground_en), .cmp_swap_en(cmp_swap_en), .cmp1_level(cmp1_level), .cmp2_level(cmp2_level)
    );
    ais_analog_model #(.LAG(2)) partner (.mclk(mclk), .swap_en(cmp_swap_en), .cmp1_true(cmp1_true),
        .cmp2_true(cmp2_true), .cmp1_raw(cmp1_raw), .cmp2_raw(cmp2_raw));
    // ------------------------------
    // expectations and tasks
    // ------------------------------
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // expected switch enables from control byte c and shift bits x
    function automatic logic [12:0] exp_out(input logic [7:0] c, input logic [1:0] x);
        logic h;
        h = c[7:6] == 2'b00;
        return {h, c[7:6] == 2'b01, c[7:6] == 2'b10, c[7:6] == 2'b11, h && x == 2'b11, !h,
                c[3:0], c[4] && c[3:0] == 4'h0, !c[4] && c[3:0] == 4'h0, c[5]};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one bus transfer; request held until waitrequest is seen low at an edge
    task automatic bus_op(input logic [3:0] a, input logic wr, input logic [3:0] be, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        address <= a;
        write <= wr;
        read <= !wr;
        byteenable <= be;
        writedata <= {24'h00_0000, d};
        do begin
            @(posedge mclk);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        rd = readdata;
        rs = response;
        read <= 1'b0;
        write <= 1'b0;
        if (n >= 20) failures++;
        #1;
    endtask
    // sample bits dropped first, then selects changed, then sampling resumed
    task automatic set_ctl(input logic [7:0] c);
        bus_op(ais_pkg::CTL_OFFSET, 1'b1, 4'hf, {2'b00, cur_q[5:0]});
        bus_op(ais_pkg::CTL_OFFSET, 1'b1, 4'hf, {2'b00, c[5:0]});
        bus_op(ais_pkg::CTL_OFFSET, 1'b1, 4'hf, c);
        cur_q = c;
    endtask
    task automatic check_state;
        check(32'(outs), 32'(exp_out(cur_q, aux_q)));
        bus_op(ais_pkg::CTL_OFFSET, 1'b0, 4'hf, 8'h00);
        check(rd, {24'h00_0000, cur_q});
        bus_op(ais_pkg::AUX_OFFSET, 1'b0, 4'hf, 8'h00);
        check(rd, {30'h0000_0000, aux_q});
        bus_op(ais_pkg::STAT_OFFSET, 1'b0, 4'hf, 8'h00);
        check(32'(rd[5:3]), 32'({cur_q[4] && !cur_q[3:0], !cur_q[4:0], 1'b0}));
    endtask
    task automatic do_reset;
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        #1;
        cur_q = 8'h80;
        aux_q = 2'b00;
        check_state;
    endtask
    task automatic end_of_test;
        if (failures == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ------------------------------
    // main sequence
    // ------------------------------
    initial begin
        do_reset;
        for (int i = 0; i < 24; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            aux_q = (i < 8) ? 2'(i) : lfsr_q[9:8];
            bus_op(ais_pkg::AUX_OFFSET, 1'b1, 4'hf, {6'h00, aux_q});
            set_ctl((i < 8) ? corner[i] : lfsr_q[7:0]);
            check_state;
        end
        // refused accesses and a write without lane 0 leave the registers untouched
        bus_op(4'hc, 1'b0, 4'hf, 8'h00);
        check({30'h0000_0000, rs}, 32'(ais_pkg::RESP_DECODE_ERR));
        bus_op(4'hc, 1'b1, 4'hf, 8'h55);
        bus_op(ais_pkg::CTL_OFFSET, 1'b1, 4'he, 8'h55);
        check({30'h0000_0000, rs}, 32'(ais_pkg::RESP_OKAY));
        check_state;
        // swap toggles: flag sense must not move, stale flags cleared after
        for (int s = 0; s < 2; s++) begin
            bus_op(ais_pkg::STAT_OFFSET, 1'b1, 4'hf, 8'h0c);
            set_ctl(cur_q ^ 8'h20);
            bus_op(ais_pkg::STAT_OFFSET, 1'b0, 4'hf, 8'h00);
            check(32'(rd[2]), 32'h0000_0001);
            bus_op(ais_pkg::STAT_OFFSET, 1'b1, 4'hf, 8'h0c);
            for (int k = 0; k < 4; k++) begin
                @(posedge mclk);
                lfsr_q = lfsr_next(lfsr_q);
                cmp1_true <= lfsr_q[0];
                cmp2_true <= lfsr_q[1];
                repeat (8) @(posedge mclk);
                #1;
                check(32'({cmp1_level, cmp2_level}), 32'({lfsr_q[0], lfsr_q[1]}));
            end
        end
        @(posedge mclk);
        do_reset;
        end_of_test;
    end
    // hang guard, far beyond the fewer than one thousand cycles the tests need
    initial begin
        #1000000;
        failures++;
        end_of_test;
    end
endmodule
bind ais_top ais_assertions chk (
    .mclk(mclk), .rst(rst), .address(address), .read(read), .write(write), .byteenable(byteenable),
    .writedata(writedata), .readdata(readdata), .response(response), .waitrequest(waitrequest),
    .cmp1_raw(cmp1_raw), .cmp2_raw(cmp2_raw), .cap_hold_en(cap_hold_en), .cap_halved_en(cap_halved_en),
    .cap_direct_en(cap_direct_en), .cap_diode_en(cap_diode_en), .cap_offset_en(cap_offset_en),
    .cap_offset_bypass(cap_offset_bypass), .bus_pin_en(bus_pin_en), .bus_supply_en(bus_supply_en),
    .bus_ground_en(bus_ground_en), .cmp_swap_en(cmp_swap_en), .cmp1_level(cmp1_level), .cmp2_level(cmp2_level)
);
